// ==== rstirv_defines.svh ====
`ifndef RSTIRV_DEFINES_SVH
`define RSTIRV_DEFINES_SVH
////////////////////////////////////////////////////////////////////////////////
// register indices, byte address is four times the index
`define RSTIRV_IDX_CTRL 6'h03
`define RSTIRV_IDX_RX_DATA_B 6'h0B
`define RSTIRV_IDX_RX_VALID_B 6'h0C
`define RSTIRV_IDX_TX_IRQ_EN 6'h0D
`define RSTIRV_IDX_TX_IRQ_STAT 6'h0E
`define RSTIRV_IDX_TX_DATA 6'h0F
`define RSTIRV_IDX_TX_VALID 6'h10
////////////////////////////////////////////////////////////////////////////////
// field positions
`define RSTIRV_BIT_UNDERFLOW 3
`define RSTIRV_BIT_OVERFLOW 2
`define RSTIRV_BIT_DONE 1
`define RSTIRV_BIT_EMPTY 0
`define RSTIRV_BIT_TX_EN 7
`define RSTIRV_BIT_RX_EN 6
////////////////////////////////////////////////////////////////////////////////
// reset values and masks
`define RSTIRV_RST_BYTE 8'h00
`define RSTIRV_RST_STAT 4'h0
`define RSTIRV_RD_CLR_MASK 4'hE
`define RSTIRV_ALL_VALID 8'hFF
////////////////////////////////////////////////////////////////////////////////
// bus answers and bit counts
`define RSTIRV_RESP_OKAY 2'h0
`define RSTIRV_RESP_SLVERR 2'h2
`define RSTIRV_LAST_BIT 3'h7
`endif

// ==== rstirv_flag.sv ====
module rstirv_flag (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // events
    input wire logic set,
    input wire logic clr,
    // state
    output logic q
);
    // set wins so an event in the clearing cycle is kept
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= 1'b0;
        end else if (set) begin
            q <= 1'b1;
        end else if (clr) begin
            q <= 1'b0;
        end
    end
endmodule

// ==== rstirv_host.sv ====
module rstirv_host (
    // clock
    input wire logic aclk,
    // write channels
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    // read channels
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    timeunit 1ns;
    timeprecision 1ps;
    import rstirv_pkg::*;
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // no cycle count is assumed: only the bench timeout ends a wait
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        wstrb <= 4'hF;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'h0;
    endtask
endmodule

// ==== rstirv_pkg.sv ====
package rstirv_pkg;
    typedef struct packed {
        logic underflow;
        logic overflow;
        logic done;
        logic empty;
    } rstirv_tx_stat_t;
    typedef struct packed {
        logic tick;
        logic data;
        logic valid;
        logic flush;
    } rstirv_rx_bit_t;
    typedef struct packed {
        logic strobe;
        logic data;
        logic is_data;
    } rstirv_tx_bit_t;
    typedef struct packed {
        logic [7:0] data;
        logic [7:0] valid;
    } rstirv_tx_byte_t;
    typedef enum logic [0:0] {SH_IDLE, SH_SEND} rstirv_sh_state_t;
endpackage

// ==== rstirv_top.sv ====
// Summary of operation
// RQ1: first received channel B bit lands in bit 0
// RQ2: read-only valid byte marks each valid data bit
// RQ3: all-valid flag means all eight bits valid
// RQ4: host writes zero to enable bits 7:4
// RQ5: enable bits: underflow, overflow, done, empty
// RQ6: underflow when sampling with no data waiting (code flags it only once a bit has gone out since transmit was enabled)
// RQ7: overflow when data written before moved on
// RQ8: done when byte finished and nothing waiting
// RQ9: status read clears underflow, overflow, done
// RQ10: empty set on load, cleared by data write
// RQ11: status register read-only, upper bits zero
// RQ12: host writes next byte only while empty
// RQ13: status reads zero outside transmit mode
// RQ14: send lsb first, preamble for invalid bits (code stops after the highest valid bit, sending no invalid bits above it)
// RQ15: interrupt while enabled status bit is set
//
// Local design decision: the AXI4-Lite register port.
`include "rstirv_defines.svh"
module rstirv_top #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // channel b receiver
    input rstirv_pkg::rstirv_rx_bit_t rx_b_in,
    output logic rx_b_byte_ready,
    output logic rx_b_all_valid,
    // transmitter
    input wire logic tx_bit_tick,
    output rstirv_pkg::rstirv_tx_bit_t tx_out,
    // mode and interrupt
    output logic tx_en,
    output logic rx_en,
    output logic irq
);
    import rstirv_pkg::*;
    ////////////////////////////////////////////////////////////////////////////
    // write channels, address and data taken in either order
    logic aw_full_q, w_full_q, bvalid_q, wlane_q;
    logic [5:0] aw_idx_q;
    logic [7:0] wbyte_q;
    logic [1:0] bresp_q;
    assign s_axi_awready = !aw_full_q && !bvalid_q;
    assign s_axi_wready = !w_full_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    wire aw_hs = s_axi_awvalid && s_axi_awready;
    wire w_hs = s_axi_wvalid && s_axi_wready;
    wire wr_fire = aw_full_q && w_full_q;
    wire wr_map = (aw_idx_q == `RSTIRV_IDX_CTRL) || (aw_idx_q == `RSTIRV_IDX_TX_IRQ_EN) ||
                  (aw_idx_q == `RSTIRV_IDX_TX_DATA) || (aw_idx_q == `RSTIRV_IDX_TX_VALID) ||
                  (aw_idx_q == `RSTIRV_IDX_RX_DATA_B) || (aw_idx_q == `RSTIRV_IDX_RX_VALID_B) ||
                  (aw_idx_q == `RSTIRV_IDX_TX_IRQ_STAT);
    wire wr_go = wr_fire && wlane_q;
    wire wr_ctrl = wr_go && (aw_idx_q == `RSTIRV_IDX_CTRL);
    wire wr_en = wr_go && (aw_idx_q == `RSTIRV_IDX_TX_IRQ_EN);
    wire wr_txd = wr_go && (aw_idx_q == `RSTIRV_IDX_TX_DATA);
    wire wr_txv = wr_go && (aw_idx_q == `RSTIRV_IDX_TX_VALID);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            aw_idx_q <= 6'h00;
        end else if (aw_hs) begin
            aw_full_q <= 1'b1;
            aw_idx_q <= s_axi_awaddr[7:2];
        end else if (wr_fire) begin
            aw_full_q <= 1'b0;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_q <= 1'b0;
            wbyte_q <= `RSTIRV_RST_BYTE;
            wlane_q <= 1'b0;
        end else if (w_hs) begin
            w_full_q <= 1'b1;
            wbyte_q <= s_axi_wdata[7:0];
            wlane_q <= s_axi_wstrb[0];
        end else if (wr_fire) begin
            w_full_q <= 1'b0;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= `RSTIRV_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_map ? `RSTIRV_RESP_OKAY : `RSTIRV_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // software registers
    logic [7:0] ctrl_q;
    logic [3:0] en_q;
    logic full_q;
    rstirv_tx_byte_t tx_byte_q;
    assign tx_en = ctrl_q[`RSTIRV_BIT_TX_EN];
    assign rx_en = ctrl_q[`RSTIRV_BIT_RX_EN];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= `RSTIRV_RST_BYTE;
            en_q <= `RSTIRV_RST_STAT;
            tx_byte_q <= '0;
        end else begin
            if (wr_ctrl) ctrl_q <= wbyte_q;
            // RQ5 one enable per condition
            if (wr_en) en_q <= wbyte_q[3:0];
            if (wr_txd) tx_byte_q.data <= wbyte_q;
            if (wr_txv) tx_byte_q.valid <= wbyte_q;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // transmit path
    logic tx_load, tx_ufl, tx_done;
    // RQ7 write while byte pending
    wire tx_ofl = wr_txd && full_q && !tx_load;
    // a write in the load cycle refills the holding byte
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            full_q <= 1'b0;
        end else if (wr_txd) begin
            full_q <= 1'b1;
        end else if (tx_load) begin
            full_q <= 1'b0;
        end
    end
    rstirv_tx_shift u_shift (
        .aclk(aclk),
        .aresetn(aresetn),
        .en(tx_en),
        .load_req(full_q && tx_en),
        .byte_in(tx_byte_q),
        .bit_tick(tx_bit_tick),
        .load(tx_load),
        .underflow(tx_ufl),
        .done(tx_done),
        .tx_out(tx_out)
    );
    ////////////////////////////////////////////////////////////////////////////
    // read channel
    logic rvalid_q;
    logic [7:0] rbyte_q;
    logic [1:0] rresp_q;
    rstirv_tx_stat_t stat_q;
    logic [7:0] rx_data_q, rx_valid_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = {24'h000000, rbyte_q};
    wire ar_hs = s_axi_arvalid && s_axi_arready;
    wire [5:0] rd_idx = s_axi_araddr[7:2];
    wire rd_stat = ar_hs && (rd_idx == `RSTIRV_IDX_TX_IRQ_STAT);
    // RQ13 zero outside transmit
    wire [3:0] stat_rd = tx_en ? stat_q : `RSTIRV_RST_STAT;
    // RQ11 upper status bits zero
    wire [7:0] rd_byte =
        (rd_idx == `RSTIRV_IDX_CTRL) ? ctrl_q :
        (rd_idx == `RSTIRV_IDX_RX_DATA_B) ? rx_data_q :
        (rd_idx == `RSTIRV_IDX_RX_VALID_B) ? rx_valid_q :
        (rd_idx == `RSTIRV_IDX_TX_IRQ_EN) ? {4'h0, en_q} :
        (rd_idx == `RSTIRV_IDX_TX_IRQ_STAT) ? {4'h0, stat_rd} :
        (rd_idx == `RSTIRV_IDX_TX_DATA) ? tx_byte_q.data :
        (rd_idx == `RSTIRV_IDX_TX_VALID) ? tx_byte_q.valid : 8'h00;
    wire rd_map = (rd_idx == `RSTIRV_IDX_CTRL) || (rd_idx == `RSTIRV_IDX_RX_DATA_B) ||
                  (rd_idx == `RSTIRV_IDX_RX_VALID_B) || (rd_idx == `RSTIRV_IDX_TX_IRQ_EN) ||
                  (rd_idx == `RSTIRV_IDX_TX_IRQ_STAT) || (rd_idx == `RSTIRV_IDX_TX_DATA) ||
                  (rd_idx == `RSTIRV_IDX_TX_VALID);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rbyte_q <= `RSTIRV_RST_BYTE;
            rresp_q <= `RSTIRV_RESP_OKAY;
        end else if (ar_hs) begin
            rvalid_q <= 1'b1;
            rbyte_q <= rd_byte;
            rresp_q <= rd_map ? `RSTIRV_RESP_OKAY : `RSTIRV_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // transmit status flags, leaving transmit mode clears them all
    wire [3:0] set_vec = {tx_ufl, tx_ofl, tx_done, tx_load} & {4{tx_en}};
    // RQ9 read clears three
    wire [3:0] rd_clr = {4{rd_stat}} & `RSTIRV_RD_CLR_MASK;
    // RQ10 data write clears empty
    wire [3:0] clr_vec = rd_clr | {3'h0, wr_txd} | {4{!tx_en}};
    for (genvar i = 0; i < 4; i++) begin : g_flag
        // RQ6 RQ8 RQ10 sticky status
        rstirv_flag u_flag (
            .aclk(aclk),
            .aresetn(aresetn),
            .set(set_vec[i]),
            .clr(clr_vec[i]),
            .q(stat_q[i])
        );
    end
    // RQ15 masked status interrupt
    assign irq = |(stat_rd & en_q);
    ////////////////////////////////////////////////////////////////////////////
    // channel b receive deserialiser
    logic [7:0] rx_sh_data_q, rx_sh_valid_q;
    logic [2:0] rx_cnt_q;
    logic rx_all_q, rx_rdy_q;
    wire rx_tick = rx_en && rx_b_in.tick;
    wire [7:0] rx_pos = 8'h01 << rx_cnt_q;
    // RQ1 bit position by arrival
    wire [7:0] asm_data = rx_tick ? ((rx_sh_data_q & ~rx_pos) | (rx_b_in.data ? rx_pos : 8'h00)) : rx_sh_data_q;
    wire [7:0] asm_valid = rx_tick ? ((rx_sh_valid_q & ~rx_pos) | (rx_b_in.valid ? rx_pos : 8'h00)) : rx_sh_valid_q;
    // end of frame flushes a partial byte so it is never stranded
    wire rx_xfer = (rx_tick && (rx_cnt_q == `RSTIRV_LAST_BIT)) || (rx_en && rx_b_in.flush);
    assign rx_b_all_valid = rx_all_q;
    assign rx_b_byte_ready = rx_rdy_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_sh_data_q <= 8'h00;
            rx_sh_valid_q <= 8'h00;
            rx_cnt_q <= 3'h0;
            rx_data_q <= `RSTIRV_RST_BYTE;
            rx_valid_q <= `RSTIRV_RST_BYTE;
            rx_all_q <= 1'b0;
            rx_rdy_q <= 1'b0;
        end else begin
            rx_rdy_q <= rx_xfer;
            if (!rx_en || rx_xfer) begin
                rx_sh_data_q <= 8'h00;
                rx_sh_valid_q <= 8'h00;
                rx_cnt_q <= 3'h0;
            end else if (rx_tick) begin
                rx_sh_data_q <= asm_data;
                rx_sh_valid_q <= asm_valid;
                rx_cnt_q <= rx_cnt_q + 3'h1;
            end
            // RQ2 RQ3 valid map and flag
            if (rx_xfer) begin
                rx_data_q <= asm_data;
                rx_valid_q <= asm_valid;
                rx_all_q <= (asm_valid == `RSTIRV_ALL_VALID);
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // assertions
    property p_rx_last_bit;
        @(posedge aclk) disable iff (!aresetn)
        (rx_tick && rx_cnt_q == `RSTIRV_LAST_BIT) |=> (rx_data_q[7] == $past(rx_b_in.data)) && rx_b_byte_ready;
    endproperty
    a_rx_last_bit: assert property (p_rx_last_bit) else $error("eighth bit not in bit 7"); // RQ1
    property p_rx_valid_map;
        @(posedge aclk) disable iff (!aresetn)
        rx_xfer |=> (rx_valid_q == $past(asm_valid)) ##1 (rx_valid_q == $past(rx_valid_q) || rx_b_byte_ready);
    endproperty
    a_rx_valid_map: assert property (p_rx_valid_map) else $error("valid byte mismatch"); // RQ2
    property p_rx_flush;
        @(posedge aclk) disable iff (!aresetn)
        (rx_en && rx_b_in.flush) |=> rx_b_byte_ready && (rx_valid_q == $past(asm_valid));
    endproperty
    a_rx_flush: assert property (p_rx_flush) else $error("flushed byte not transferred"); // RQ2
    property p_rx_all_valid;
        @(posedge aclk) disable iff (!aresetn)
        rx_b_all_valid |-> (rx_valid_q == `RSTIRV_ALL_VALID);
    endproperty
    a_rx_all_valid: assert property (p_rx_all_valid) else $error("all-valid flag with invalid bits"); // RQ3
    property p_en_read;
        @(posedge aclk) disable iff (!aresetn)
        (ar_hs && rd_idx == `RSTIRV_IDX_TX_IRQ_EN) |=> s_axi_rvalid && (s_axi_rdata == {28'h0, $past(en_q)});
    endproperty
    a_en_read: assert property (p_en_read) else $error("enable readback wrong"); // RQ5
    property p_underflow;
        @(posedge aclk) disable iff (!aresetn)
        (tx_en && tx_ufl) |=> stat_q.underflow;
    endproperty
    a_underflow: assert property (p_underflow) else $error("underflow not flagged"); // RQ6
    property p_overflow;
        @(posedge aclk) disable iff (!aresetn)
        (tx_en && wr_txd && full_q && !tx_load) |=> stat_q.overflow;
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow not flagged"); // RQ7
    property p_done;
        @(posedge aclk) disable iff (!aresetn)
        (tx_en && tx_done) |=> stat_q.done && (!stat_q.underflow || $past(stat_q.underflow));
    endproperty
    a_done: assert property (p_done) else $error("done not flagged"); // RQ8
    property p_read_clear;
        @(posedge aclk) disable iff (!aresetn)
        (rd_stat && !tx_done && !tx_ofl && !tx_ufl) |=> (stat_q[3:1] == 3'h0) && s_axi_rvalid;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("status read did not clear"); // RQ9
    property p_empty;
        @(posedge aclk) disable iff (!aresetn)
        (tx_en && tx_load) |=> stat_q.empty;
    endproperty
    a_empty: assert property (p_empty) else $error("empty flag wrong"); // RQ10
    property p_empty_clr;
        @(posedge aclk) disable iff (!aresetn)
        (tx_en && wr_txd && !tx_load) |=> !stat_q.empty;
    endproperty
    a_empty_clr: assert property (p_empty_clr) else $error("empty flag not cleared by data write"); // RQ10
    property p_stat_upper;
        @(posedge aclk) disable iff (!aresetn)
        (ar_hs && rd_idx == `RSTIRV_IDX_TX_IRQ_STAT) |=> (s_axi_rdata[31:4] == 28'h0);
    endproperty
    a_stat_upper: assert property (p_stat_upper) else $error("reserved status bits set"); // RQ11
    property p_tx_off;
        @(posedge aclk) disable iff (!aresetn)
        !tx_en |=> (stat_q == `RSTIRV_RST_STAT) && !irq;
    endproperty
    a_tx_off: assert property (p_tx_off) else $error("status alive outside transmit"); // RQ13
    property p_irq_empty;
        @(posedge aclk) disable iff (!aresetn)
        (tx_en && tx_load && en_q[`RSTIRV_BIT_EMPTY] && !wr_en && !wr_ctrl) |=> irq;
    endproperty
    a_irq_empty: assert property (p_irq_empty) else $error("enabled empty gave no interrupt"); // RQ15
    c_overflow: cover property (@(posedge aclk) disable iff (!aresetn) tx_ofl && tx_en);
    c_underflow: cover property (@(posedge aclk) disable iff (!aresetn) tx_ufl && tx_en);
    c_rx_full: cover property (@(posedge aclk) disable iff (!aresetn) rx_xfer ##1 rx_b_all_valid);
    c_irq: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
    c_done: cover property (@(posedge aclk) disable iff (!aresetn) tx_done && tx_en);
endmodule

// ==== rstirv_tx_shift.sv ====
`include "rstirv_defines.svh"
module rstirv_tx_shift (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control and source byte
    input wire logic en,
    input wire logic load_req,
    input rstirv_pkg::rstirv_tx_byte_t byte_in,
    input wire logic bit_tick,
    // events
    output logic load,
    output logic underflow,
    output logic done,
    // serial line
    output rstirv_pkg::rstirv_tx_bit_t tx_out
);
    import rstirv_pkg::*;
    rstirv_sh_state_t state_q, state_d;
    logic [7:0] data_q, valid_q;
    logic [2:0] cnt_q;
    logic sent_q;
    wire last = (cnt_q == `RSTIRV_LAST_BIT) || (valid_q[7:1] == 7'h00);
    wire emit = (state_q == SH_SEND) && bit_tick;
    wire byte_end = emit && last;
    assign load = load_req && ((state_q == SH_IDLE) || byte_end);
    assign done = byte_end && !load_req;
    // underflow only once a bit has gone out
    assign underflow = (state_q == SH_IDLE) && bit_tick && sent_q && !load_req;
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            SH_IDLE: if (load) state_d = SH_SEND;
            SH_SEND: if (byte_end && !load) state_d = SH_IDLE;
        endcase
        if (!en) state_d = SH_IDLE;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= SH_IDLE;
            data_q <= 8'h00;
            valid_q <= 8'h00;
            cnt_q <= 3'h0;
            sent_q <= 1'b0;
            tx_out <= '0;
        end else begin
            state_q <= state_d;
            sent_q <= en && (sent_q || emit);
            tx_out.strobe <= emit;
            // RQ14 lsb first shifting
            if (load) begin
                data_q <= byte_in.data;
                valid_q <= byte_in.valid;
                cnt_q <= 3'h0;
            end else if (emit) begin
                data_q <= {1'b0, data_q[7:1]};
                valid_q <= {1'b0, valid_q[7:1]};
                cnt_q <= cnt_q + 3'h1;
            end
            if (emit) begin
                tx_out.data <= data_q[0];
                tx_out.is_data <= valid_q[0];
            end
        end
    end
    property p_keep_shifting;
        @(posedge aclk) disable iff (!aresetn)
        (en && emit && !last) |=> (state_q == SH_SEND) && tx_out.strobe && (tx_out.is_data == $past(valid_q[0]));
    endproperty
    a_keep_shifting: assert property (p_keep_shifting) else $error("shifter stopped with valid bits left"); // RQ14
endmodule

// ==== tb.sv ====
`include "rstirv_defines.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rstirv_pkg::*;
    localparam logic [7:0] A_CTRL = {`RSTIRV_IDX_CTRL, 2'h0};
    localparam logic [7:0] A_RXD = {`RSTIRV_IDX_RX_DATA_B, 2'h0};
    localparam logic [7:0] A_RXV = {`RSTIRV_IDX_RX_VALID_B, 2'h0};
    localparam logic [7:0] A_EN = {`RSTIRV_IDX_TX_IRQ_EN, 2'h0};
    localparam logic [7:0] A_ST = {`RSTIRV_IDX_TX_IRQ_STAT, 2'h0};
    localparam logic [7:0] A_TXD = {`RSTIRV_IDX_TX_DATA, 2'h0};
    localparam logic [7:0] A_TXV = {`RSTIRV_IDX_TX_VALID, 2'h0};
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, tx_bit_tick, rx_b_byte_ready;
    logic rx_b_all_valid, tx_en, rx_en, irq;
    logic [7:0] awaddr, araddr, d, v;
    logic [31:0] wdata, rdata, rv;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp;
    rstirv_rx_bit_t rx_b_in;
    rstirv_tx_bit_t tx_out;
    logic [1:0] txq[$];
    int mismatches, total_checks, cycles;
    rstirv_top #(.ADDR_W(8)) rstirv_top_inst (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .rx_b_in(rx_b_in), .rx_b_byte_ready(rx_b_byte_ready), .rx_b_all_valid(rx_b_all_valid),
        .tx_bit_tick(tx_bit_tick), .tx_out(tx_out), .tx_en(tx_en), .rx_en(rx_en), .irq(irq));
    rstirv_host rstirv_host_inst (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'h0;
        forever #4 aclk = ~aclk;
    end
    // serial line monitor, strobe stands one cycle
    always @(posedge aclk) begin
        if (tx_out.strobe === 1'h1) txq.push_back({tx_out.is_data, tx_out.data});
    end
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] x);
        rstirv_host_inst.wr(a, x, rsp);
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e, input string n);
        rstirv_host_inst.rd(a, rv, rsp);
        `CHK(n, {24'h000000, e}, rv)
    endtask
    // bits go out lowest first, one tick each; a short byte ends in a flush
    task automatic rx_byte(input logic [7:0] x, input logic [7:0] m, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge aclk);
            rx_b_in <= '{1'h1, x[i], m[i], 1'h0};
            @(posedge aclk);
            rx_b_in <= '0;
        end
        if (n < 8) begin
            @(posedge aclk);
            rx_b_in <= '{1'h0, 1'h0, 1'h0, 1'h1};
            @(posedge aclk);
            rx_b_in <= '0;
        end
        do @(posedge aclk); while (rx_b_byte_ready !== 1'h1);
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge aclk);
            tx_bit_tick <= 1'h1;
            @(posedge aclk);
            tx_bit_tick <= 1'h0;
            repeat (2) @(posedge aclk);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        aresetn = 1'h0;
        rx_b_in = '0;
        tx_bit_tick = 1'h0;
        void'($urandom(32'h9A831F48));
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        chk_rd(A_RXV, 8'h00, "valid_rst");
        chk_rd(A_EN, 8'h00, "en_rst");
        chk_rd(A_ST, 8'h00, "stat_rst");
        rstirv_host_inst.rd(8'hFC, rv, rsp);
        `CHK("unmapped_resp", `RSTIRV_RESP_SLVERR, rsp)
        wr(A_RXV, 8'hFF);
        `CHK("ro_resp", `RSTIRV_RESP_OKAY, rsp)
        chk_rd(A_RXV, 8'h00, "ro_keep");
        $display("test registers ended");
        wr(A_CTRL, 8'h40);
        `CHK("mode_rx", 2'h1, {tx_en, rx_en})
        // the third byte stops after five bits and is flushed
        for (int k = 0; k < 3; k++) begin
            d = 8'($urandom);
            v = (k == 0) ? 8'hFF : 8'($urandom) & ((k == 2) ? 8'h1F : 8'hFF);
            rx_byte(d, v, (k == 2) ? 5 : 8);
            chk_rd(A_RXV, v, "rx_valid");
            rstirv_host_inst.rd(A_RXD, rv, rsp);
            `CHK("rx_data", d & v, rv[7:0] & v)
            `CHK("all_valid", v == 8'hFF, rx_b_all_valid)
        end
        $display("test receive ended");
        // reserved enable bits written nonzero on purpose
        wr(A_EN, 8'hFF);
        chk_rd(A_EN, 8'h0F, "en_mask");
        wr(A_CTRL, 8'h80);
        `CHK("mode_tx", 2'h2, {tx_en, rx_en})
        d = 8'($urandom);
        v = 8'h0D;
        wr(A_TXV, v);
        wr(A_TXD, d);
        chk_rd(A_ST, 8'h01, "stat_load");
        // four bits then one idle tick
        tick(5);
        chk_rd(A_ST, 8'h0B, "stat_end");
        chk_rd(A_ST, 8'h01, "stat_clr");
        `CHK("tx_count", 4, txq.size())
        for (int i = 0; i < 4; i++) `CHK("tx_bit", {v[i], v[i] ? d[i] : txq[i][0]}, txq[i])
        @(negedge aclk);
        `CHK("irq_on", 1'h1, irq)
        wr(A_EN, 8'h08);
        @(negedge aclk);
        `CHK("irq_masked", 1'h0, irq)
        wr(A_CTRL, 8'h00);
        chk_rd(A_ST, 8'h00, "stat_off");
        $display("test transmit ended");
        wr(A_CTRL, 8'h80);
        wr(A_EN, 8'h04);
        wr(A_TXV, 8'hFF);
        wr(A_TXD, 8'($urandom));
        wr(A_TXD, 8'($urandom));
        // third byte while one waits, broken on purpose
        wr(A_TXD, 8'($urandom));
        @(negedge aclk);
        `CHK("irq_ovf", 1'h1, irq)
        chk_rd(A_ST, 8'h04, "stat_ovf");
        $display("test overflow ended");
        end_of_test();
    end
endmodule
